// *** src/core_timer_pkg.sv ***
// core timer package: register offsets, control field layout, reset values
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`default_nettype none
package core_timer_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0C;
  // control field positions
  localparam int PRESCALE_LSB = 0;
  localparam int RUN_BIT = 6;
  localparam int DOWN_BIT = 7;
  localparam int TOGGLE_OE_BIT = 9;
  localparam int TOGGLE_BIT = 10;
  localparam int RELOAD_EN_BIT = 15;
  // irq control field positions
  localparam int REQ_ENABLE_BIT = 6;
  localparam int REQ_FLAG_BIT = 7;
  localparam int REQ_ROUTE_BIT = 3;
  // writable control bits
  localparam logic [15:0] CONTROL_MASK = 16'h86C7;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  // base prescale: oscillator divided by eight
  localparam int BASE_DIV = 8;
  localparam int PRESCALE_W = 10;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;

  typedef struct packed {
    logic wrap;
    logic toggle;
    logic up_edge;
  } timer_event_s;
endpackage
`default_nettype wire

// *** src/core_timer.sv ***
// core timer: 16-bit up/down timer with prescaler, toggle latch and reload
// assumes one 200 MHz clock, synchronous high reset, one AHB-Lite master
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`default_nettype none
module core_timer
  import core_timer_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // toggle pin and gpio fallback
  input wire logic I_GPIO_OUT,
  output logic O_TOGGLE_PIN,
  // request outputs
  output logic O_IRQ,
  output logic O_PEC_REQ,
  // internal links to other timers
  output logic O_AUX_TOGGLE,
  output logic O_AUX_EVENT,
  output logic O_CAPTURE_COMPARE_UNIT_TICK
);

  logic [15:0] ctrl_q;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] reload_q;
  logic req_flag_q;
  logic req_en_q;
  logic req_route_q;
  logic [PRESCALE_W-1:0] pre_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;

  // control fields
  wire logic [2:0] prescale_select = ctrl_q[PRESCALE_LSB +: 3];
  wire logic core_run = ctrl_q[RUN_BIT];
  wire logic count_down_select = ctrl_q[DOWN_BIT];
  wire logic toggle_output_enable = ctrl_q[TOGGLE_OE_BIT];
  wire logic overflow_toggle_latch = ctrl_q[TOGGLE_BIT];
  wire logic reload_enable = ctrl_q[RELOAD_EN_BIT];

  // prescaler: tick when low bits of free counter all one
  wire logic [PRESCALE_W-1:0] pre_mask =
    PRESCALE_W'((BASE_DIV << prescale_select) - 1);
  wire logic tick = core_run && ((pre_q & pre_mask) == pre_mask);

  // wrap detection
  wire logic wrap = tick && (count_down_select ? (count_q == COUNT_W'(COUNT_MIN))
    : (count_q == COUNT_W'(COUNT_MAX)));
  wire logic [COUNT_W-1:0] count_step = count_down_select ?
    count_q - COUNT_W'(1) : count_q + COUNT_W'(1);

  // register select, decoded separately for the held write address and the live read address
  typedef enum logic [2:0] {
    SEL_CONTROL,
    SEL_COUNT,
    SEL_RELOAD,
    SEL_IRQ,
    SEL_NONE
  } reg_sel_e;

  // unmapped offsets fall through to no register
  function automatic reg_sel_e decode_reg(input logic [7:0] ofs);
    reg_sel_e sel;
    if (ofs == OFS_CONTROL)
    begin
      sel = SEL_CONTROL;
    end
    else if (ofs == OFS_COUNT)
    begin
      sel = SEL_COUNT;
    end
    else if (ofs == OFS_RELOAD)
    begin
      sel = SEL_RELOAD;
    end
    else if (ofs == OFS_IRQ_CTRL)
    begin
      sel = SEL_IRQ;
    end
    else
    begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  // bus decode
  wire logic addr_phase = I_HSEL && I_HREADY && I_HTRANS[1];
  wire logic rd_phase = addr_phase && !I_HWRITE;
  wire logic wr_phase = addr_phase && I_HWRITE;
  wire logic [7:0] rd_addr = I_HADDR[7:0];
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  assign wr_sel = decode_reg(wr_addr_q);
  assign rd_sel = decode_reg(rd_addr);
  wire logic wr_ctrl = wr_pend_q && (wr_sel == SEL_CONTROL);
  wire logic wr_count = wr_pend_q && (wr_sel == SEL_COUNT);
  wire logic wr_reload = wr_pend_q && (wr_sel == SEL_RELOAD);
  wire logic wr_irq = wr_pend_q && (wr_sel == SEL_IRQ);

  // wrap event bundle for the other timers
  timer_event_s evt;
  assign evt.wrap = wrap;
  assign evt.toggle = wrap;
  assign evt.up_edge = wrap && !overflow_toggle_latch;

  // next control: software writes the CONTROL_MASK bits, hardware toggle wins afterward
  logic [15:0] ctrl_d;
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d = I_HWDATA[15:0] & CONTROL_MASK;
    end
    if (wrap)
    begin
      ctrl_d[TOGGLE_BIT] = ~overflow_toggle_latch;
    end
  end

  // next count
  logic [COUNT_W-1:0] count_d;
  always_comb
  begin
    count_d = count_q;
    if (wr_count)
    begin
      count_d = I_HWDATA[COUNT_W-1:0];
    end
    else if (wrap && reload_enable)
    begin
      count_d = reload_q;
    end
    else if (tick)
    begin
      count_d = count_step;
    end
  end

  // read mux
  wire logic [31:0] irq_word =
    {24'h000000, req_flag_q, req_en_q, 2'b00, req_route_q, 3'b000};
  wire logic [31:0] rd_val =
    (rd_sel == SEL_CONTROL) ? {16'h0000, ctrl_q} :
    (rd_sel == SEL_COUNT) ? {{(32-COUNT_W){1'b0}}, count_q} :
    (rd_sel == SEL_RELOAD) ? {{(32-COUNT_W){1'b0}}, reload_q} :
    (rd_sel == SEL_IRQ) ? irq_word :
    32'h00000000;

  // control register
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      ctrl_q <= CONTROL_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // counter register
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      count_q <= COUNT_W'(COUNT_RESET);
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // free-running prescaler; tick taps its low bits
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_q + PRESCALE_W'(1);
    end
  end

  // reload register
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      reload_q <= COUNT_W'(RELOAD_RESET);
    end
    else if (wr_reload)
    begin
      reload_q <= I_HWDATA[COUNT_W-1:0];
    end
  end

  // write address held into the data phase
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= wr_phase;
      if (addr_phase)
      begin
        wr_addr_q <= I_HADDR[7:0];
      end
    end
  end

  // read data, stands until the next read
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (rd_phase)
    begin
      rdata_q <= rd_val;
    end
  end

  // request flag: hardware set wins over software clear
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      req_flag_q <= 1'b0;
      req_en_q <= 1'b0;
      req_route_q <= 1'b0;
    end
    else
    begin
      if (wr_irq)
      begin
        req_en_q <= I_HWDATA[REQ_ENABLE_BIT];
        req_route_q <= I_HWDATA[REQ_ROUTE_BIT];
      end
      if (wrap)
      begin
        req_flag_q <= 1'b1;
      end
      else if (wr_irq)
      begin
        req_flag_q <= I_HWDATA[REQ_FLAG_BIT];
      end
    end
  end

  // outputs
  assign O_HRDATA = rdata_q;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_IRQ = req_flag_q && req_en_q && !req_route_q;
  assign O_PEC_REQ = req_flag_q && req_en_q && req_route_q;
  // pin output level; port latch and direction live outside
  assign O_TOGGLE_PIN = toggle_output_enable ? overflow_toggle_latch : I_GPIO_OUT;
  assign O_AUX_TOGGLE = overflow_toggle_latch;
  assign O_AUX_EVENT = evt.toggle;
  assign O_CAPTURE_COMPARE_UNIT_TICK = evt.wrap;

endmodule // core_timer
`default_nettype wire

// *** verification/core_timer_checker.sv ***
// checker: bus answer, request and wrap-event relations at the timer ports
// assumes it is bound onto core_timer, one clock, synchronous high reset
`default_nettype none
module core_timer_checker (
  // clock, reset and bus
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  // timer outputs
  input wire logic O_IRQ,
  input wire logic O_PEC_REQ,
  input wire logic O_AUX_TOGGLE,
  input wire logic O_AUX_EVENT,
  input wire logic O_CAPTURE_COMPARE_UNIT_TICK
);
  wire take = I_HSEL & I_HREADY & I_HTRANS[1];
  logic wr_q;
  logic rd_q;
  always_ff @(posedge I_SYS_CLK)
  begin
    wr_q <= take & I_HWRITE;
    rd_q <= take & !I_HWRITE;
  end
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence quiet7;
    !O_CAPTURE_COMPARE_UNIT_TICK [*7];
  endsequence
  a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus answer not ready or not okay");
  a_req_excl: assert property (!(O_IRQ && O_PEC_REQ))
    else $error("interrupt and transfer request both high");
  a_aux_cap: assert property (O_AUX_EVENT == O_CAPTURE_COMPARE_UNIT_TICK)
    else $error("auxiliary event differs from wrap tick");
  a_tick_spaced: assert property (O_CAPTURE_COMPARE_UNIT_TICK |=> quiet7)
    else $error("wrap ticks closer than eight cycles");
  a_wrap_toggles: assert property (O_CAPTURE_COMPARE_UNIT_TICK |=>
    O_AUX_TOGGLE != $past(O_AUX_TOGGLE))
    else $error("wrap did not invert toggle latch");
  a_toggle_cause: assert property ($changed(O_AUX_TOGGLE) |->
    $past(O_CAPTURE_COMPARE_UNIT_TICK) || $past(wr_q))
    else $error("toggle latch changed without wrap or write");
  a_req_rise: assert property ($rose(O_IRQ || O_PEC_REQ) |->
    $past(O_CAPTURE_COMPARE_UNIT_TICK) || $past(wr_q))
    else $error("request rose without wrap or write");
  a_req_fall: assert property ($fell(O_IRQ || O_PEC_REQ) |-> $past(wr_q))
    else $error("request fell without a write");
  a_rdata_hold: assert property ($changed(O_HRDATA) |-> rd_q)
    else $error("read data changed without a read");
endmodule // core_timer_checker
bind core_timer core_timer_checker u_chk (.*);
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: drives the timer over ahb-lite, checks results through a queue
// assumes the timer package and the bound checker
`default_nettype none
module testbench
  import core_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sel = 0, wr = 0, gpio = 0;
  logic [1:0] tr = 0;
  logic [31:0] ad = 0, hw = 0, seen;
  logic [31:0] exp_q[$];
  logic [15:0] rv;
  int err_total = 0, comparisons = 0, n;
  wire [31:0] rdata;
  wire rdy, pin, irq, peripheral_event_transfer, aux, tick;
  event shown;
  core_timer DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(sel), .I_HADDR(ad), .I_HTRANS(tr),
    .I_HWRITE(wr), .I_HSIZE(3'h2), .I_HWDATA(hw), .I_HREADY(rdy), .O_HRDATA(rdata),
    .O_HREADYOUT(rdy), .O_HRESP(), .I_GPIO_OUT(gpio), .O_TOGGLE_PIN(pin), .O_IRQ(irq),
    .O_PEC_REQ(peripheral_event_transfer), .O_AUX_TOGGLE(aux), .O_AUX_EVENT(), .O_CAPTURE_COMPARE_UNIT_TICK(tick));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // result monitor: oldest note against the value shown
  always @(shown)
  begin
    comparisons++;
    if (seen !== exp_q[0])
    begin
      err_total++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  task automatic look(input logic [31:0] v, input logic [31:0] e);
    exp_q.push_back(e);
    seen = v;
    ->shown;
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge clk);
    sel <= 1;
    tr <= 2'h2;
    wr <= w;
    ad <= {24'h0, a};
    do @(posedge clk); while (rdy !== 1'b1);
    tr <= 2'h0;
    sel <= 0;
    hw <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    #1;
    if (!w) look(rdata, e);
  endtask
  task automatic wt(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end while (tick !== 1'b1 && c < 3000);
    #1;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'hF04D));
    rv = 16'($urandom);
    repeat (5) @(posedge clk);
    rst <= 0;
    gpio <= rv[0];
    for (int a = 0; a < 20; a += 4) bus(0, 8'(a), 0, 0);
    bus(1, OFS_CONTROL, 32'hFFFF7938, 0);
    bus(0, OFS_CONTROL, 0, 0);
    look(pin, rv[0]);
    gpio <= 1;
    bus(1, OFS_CONTROL, 32'h600, 0);
    look(pin, 1);
    look(aux, 1);
    bus(1, OFS_CONTROL, 32'h200, 0);
    look(pin, 0);
    bus(1, OFS_RELOAD, rv, 0);
    bus(0, OFS_RELOAD, 0, rv);
    bus(1, OFS_COUNT, 32'hFFFF, 0);
    bus(0, OFS_COUNT, 0, 32'hFFFF);
    bus(1, OFS_IRQ_CTRL, 32'h40, 0);
    bus(1, OFS_CONTROL, 32'h8440, 0);
    wt(n);
    look(aux, 0);
    look(irq, 1);
    bus(1, OFS_CONTROL, 0, 0);
    repeat (20) @(posedge clk);
    bus(0, OFS_COUNT, 0, rv);
    bus(0, OFS_IRQ_CTRL, 0, 32'hC0);
    bus(1, OFS_IRQ_CTRL, 32'hC8, 0);
    look(peripheral_event_transfer, 1);
    bus(1, OFS_IRQ_CTRL, 32'h40, 0);
    look(peripheral_event_transfer, 0);
    bus(1, OFS_COUNT, 0, 0);
    bus(1, OFS_CONTROL, 32'hC1, 0);
    wt(n);
    look(aux, 1);
    bus(1, OFS_CONTROL, 0, 0);
    repeat (20) @(posedge clk);
    bus(0, OFS_COUNT, 0, 32'hFFFF);
    bus(1, OFS_RELOAD, 32'hFFFF, 0);
    bus(1, OFS_COUNT, 32'hFFFF, 0);
    for (int s = 0; s < 8; s++)
    begin
      bus(1, OFS_CONTROL, 32'h8040 | 32'(s), 0);
      wt(n);
      wt(n);
      look(32'(n), 32'(8 << s));
    end
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
